//--- ahp_device.sv
`timescale 1ns/1ps
// Functional notes
// - legacy mode: ready and strobe active low
// - other modes: programmable polarity for both lines
// - legacy mode is one direction only
// - optional settling delay between transfers
// - legacy input: strobe in, ready is buffer-full
// - legacy output: acknowledge in, ready is buffer-full
// - legacy input: ready asserted when word acceptable
// - legacy input: strobe before or after ready
// - legacy input: strobe deasserts ready
// - legacy input: capture data on strobe release
// - legacy input: re-ready after space and delay
// - legacy output: present data, ready, await strobe
// - peripheral takes data during ready window
// - legacy output: strobe deasserts ready
// - legacy output: next transfer after strobe rise
// - peripheral holds strobe until data taken
// - legacy output: re-ready after word and delay
// - level mode: ready held until strobe edge
// - level mode: ready low until next ready
// - delay 0 to 700 ns in 100 ns steps
// - edge latching captures on active strobe edge
module ahp_device
  import ahp_pkg::*;
(
  // clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST,
  // link
  ahp_link_if.device                   LINK,
  // configuration
  input  wire logic [1:0]              PROTO,
  input  wire logic                    DIR_OUT,
  input  wire logic                    POL_HIGH,
  input  wire logic                    EDGE_LATCH,
  input  wire logic [DLY_CODE_W-1:0]   DELAY_CODE,
  // input stream to user
  output logic                         IN_VALID,
  output logic [DATA_W-1:0]            IN_DATA,
  input  wire logic                    IN_READY,
  // output stream from user
  input  wire logic                    OUT_VALID,
  input  wire logic [DATA_W-1:0]       OUT_DATA,
  output logic                         OUT_READY,
  // status
  output logic                         BUSY
);
  import ahp_pkg::*;
  ahp_state_t           state;
  logic                 stb_s1;
  logic                 stb_s2;
  logic                 stb_prev;
  logic                 stb_act;
  logic                 stb_rise;
  logic                 stb_fall;
  logic                 active_low;
  logic                 legacy;
  logic                 enabled;
  logic                 rdy_act;
  logic [DLY_CNT_W-1:0] gap_cnt;
  logic [DATA_W-1:0]    out_reg;
  logic                 in_full;
  logic                 word_ok;
  logic                 strobe_hit;
  logic                 take_in;
  logic                 cap_release;
  logic                 cap_edge;
  logic                 in_capture;

  ////////////////////////////////////////////////////////////////////////
  // pin level of a line: the active state flipped for active-low lines
  function automatic logic pin_level(input logic act, input logic low);
    return act ^ low;
  endfunction

  assign legacy     = (PROTO == PROTO_LEGACY);
  assign enabled    = (PROTO != PROTO_IDLE);
  assign active_low = legacy | ~POL_HIGH;
  assign take_in    = ~DIR_OUT & enabled;

  ////////////////////////////////////////////////////////////////////////
  // strobe synchroniser; first stage feeds only the second
  // reset loads the idle pin level, else an active-low strobe would look
  // asserted for two cycles after reset and fake a transfer
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stb_s1 <= active_low;
      stb_s2 <= active_low;
    end else begin
      stb_s1 <= LINK.legacy_input_strobe;
      stb_s2 <= stb_s1;
    end
  end

  // edge history, kept apart so only the second stage reads the first
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stb_prev <= 1'b0;
    end else begin
      stb_prev <= stb_act;
    end
  end
  assign stb_act  = pin_level(stb_s2, active_low);
  assign stb_rise = stb_act & ~stb_prev;
  assign stb_fall = ~stb_act & stb_prev;

  // input side may only ready when the buffer has room
  assign word_ok = DIR_OUT ? OUT_VALID : ~in_full;
  // legacy input takes a strobe level already present every other
  // case needs a fresh active edge so a held strobe cannot count twice
  assign strobe_hit = (legacy && !DIR_OUT) ? stb_act : stb_rise;

  ////////////////////////////////////////////////////////////////////////
  // handshake sequencer
  // the gap is loaded at strobe release, so spacing runs from the end of
  // one transfer to the next ready, not from its start
  always_ff @(posedge SYS_CLK) begin
    if (RST || PROTO == PROTO_IDLE) begin
      state   <= AHP_IDLE;
      rdy_act <= 1'b0;
      gap_cnt <= DLY_ZERO;
    end else begin
      case (state)
        AHP_IDLE: begin
          rdy_act <= 1'b0;
          // in legacy input a strobe already active at ready time is accepted; other cases need a fresh edge
          if (word_ok) begin
            rdy_act <= 1'b1;
            state   <= AHP_READY;
          end
        end
        AHP_READY: begin
          if (strobe_hit) begin
            rdy_act <= 1'b0;
            state   <= AHP_WAIT_REL;
          end
        end
        AHP_WAIT_REL: begin
          // a new transfer waits for strobe release
          if (!stb_act) begin
            gap_cnt <= ahp_dly_cycles(DELAY_CODE);
            state   <= AHP_GAP;
          end
        end
        AHP_GAP: begin
          if (gap_cnt != DLY_ZERO) begin
            gap_cnt <= gap_cnt - 8'h01;
          end else begin
            state <= AHP_IDLE;
          end
        end
        default: state <= AHP_IDLE;
      endcase
    end
  end

  // legacy mode is unidirectional: one word per strobe, no turnaround
  // the bus turns only with the direction bit, so the ends never fight
  assign LINK.ready_line  = pin_level(rdy_act, active_low);
  assign LINK.dev_data    = out_reg;
  assign LINK.dev_data_oe = DIR_OUT & enabled;
  assign OUT_READY        = DIR_OUT & (state == AHP_IDLE) & enabled;
  assign BUSY             = (state != AHP_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // input capture select
  // release capture relies on the far end keeping data on the bus until
  // the synchronised release reaches the sequencer
  assign cap_release = legacy & ~EDGE_LATCH & (state == AHP_WAIT_REL) & stb_fall;
  assign cap_edge    = (EDGE_LATCH | ~legacy) & (state == AHP_READY) & strobe_hit;
  assign in_capture  = take_in & (cap_release | cap_edge);

  ////////////////////////////////////////////////////////////////////////
  // output word; loads only while idle, so it stays put for the whole
  // ready window in which the peripheral may sample it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      out_reg <= '0;
    end else if (OUT_VALID && OUT_READY) begin
      out_reg <= OUT_DATA;
    end
  end

  // input word
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IN_DATA <= '0;
    end else if (in_capture) begin
      IN_DATA <= LINK.data_bus;
    end
  end

  // buffer-full flag; a capture in the cycle of a pop wins
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      in_full <= 1'b0;
    end else if (in_capture) begin
      in_full <= 1'b1;
    end else if (IN_READY) begin
      in_full <= 1'b0;
    end
  end

  assign IN_VALID = in_full;
endmodule

//--- ahp_link_if.sv
`timescale 1ns/1ps
interface ahp_link_if;
  import ahp_pkg::*;
  logic              ready_line;
  logic              legacy_input_strobe;
  logic [DATA_W-1:0] dev_data;
  logic              dev_data_oe;
  logic [DATA_W-1:0] per_data;
  logic              per_data_oe;
  logic [DATA_W-1:0] data_bus;
  assign data_bus = dev_data_oe ? dev_data : per_data;
  modport device (output ready_line, output dev_data, output dev_data_oe,
                  input legacy_input_strobe, input data_bus);
  modport peripheral (input ready_line, input data_bus, output legacy_input_strobe,
                      output per_data, output per_data_oe);
endinterface

//--- ahp_peripheral.sv
`timescale 1ns/1ps
module ahp_peripheral
  import ahp_pkg::*;
(
  // clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  // link
  ahp_link_if.peripheral            LINK,
  // configuration
  input  wire logic [1:0]           PROTO,
  input  wire logic                 DIR_OUT,
  input  wire logic                 POL_HIGH,
  // user stream toward device (device input)
  input  wire logic                 TX_VALID,
  input  wire logic [DATA_W-1:0]    TX_DATA,
  output logic                      TX_READY,
  // user stream from device (device output)
  output logic                      RX_VALID,
  output logic [DATA_W-1:0]         RX_DATA
);
  import ahp_pkg::*;
  logic       active_low;
  logic       rdy_s1;
  logic       rdy_s2;
  logic       rdy_act;
  logic       stb_act;
  logic [DATA_W-1:0] out_data;
  logic [2:0] hold;
  logic       ack_seen;

  assign active_low = (PROTO == PROTO_LEGACY) | ~POL_HIGH;
  always_ff @(posedge SYS_CLK) begin
    rdy_s1 <= LINK.ready_line;
    rdy_s2 <= rdy_s1;
  end
  assign rdy_act = rdy_s2 ^ active_low;
  assign LINK.legacy_input_strobe = stb_act ^ active_low;
  assign LINK.per_data    = out_data;
  assign LINK.per_data_oe = ~DIR_OUT;
  // level mode waits for ready: a strobe held early gives the device no fresh edge
  assign TX_READY = ~DIR_OUT & ~stb_act & (hold == 3'h0) & (PROTO != PROTO_IDLE)
                    & ((PROTO == PROTO_LEGACY) | rdy_act);

  ////////////////////////////////////////////////////////////////////////
  // strobe generation; the strobe is held a few cycles so the device sees it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stb_act  <= 1'b0;
      hold     <= 3'h0;
      ack_seen <= 1'b0;
      out_data <= '0;
      RX_VALID <= 1'b0;
      RX_DATA  <= '0;
    end else begin
      RX_VALID <= 1'b0;
      if (hold != 3'h0) hold <= hold - 3'h1;
      // a strobe sent before ready must outlive the ready pulse it meets
      if (stb_act && rdy_act) ack_seen <= 1'b1;
      if (PROTO == PROTO_IDLE) begin
        stb_act <= 1'b0;
      end else if (!DIR_OUT) begin
        if (TX_VALID && TX_READY) begin
          out_data <= TX_DATA;
          stb_act  <= 1'b1;
          hold     <= 3'h4;
          ack_seen <= 1'b0;
        end else if (stb_act && hold == 3'h0 && ack_seen && !rdy_act) begin
          stb_act <= 1'b0;
          hold    <= 3'h4;
        end
      end else begin
        if (!stb_act && rdy_act && hold == 3'h0) begin
          RX_DATA  <= LINK.data_bus;
          RX_VALID <= 1'b1;
          stb_act  <= 1'b1;
          hold     <= 3'h4;
        end else if (stb_act && hold == 3'h0 && !rdy_act) begin
          stb_act <= 1'b0;
          hold    <= 3'h4;
        end
      end
    end
  end
endmodule

//--- ahp_pkg.sv
package ahp_pkg;
  localparam int DATA_W = 32;
  // protocol select
  localparam logic [1:0] PROTO_IDLE   = 2'h0;
  localparam logic [1:0] PROTO_LEGACY = 2'h1;
  localparam logic [1:0] PROTO_LEVEL  = 2'h2;
  // delay code is in steps of 100 ns, 0..7 gives 0..700 ns
  localparam int DLY_CODE_W   = 3;
  localparam int DLY_STEP_NS  = 100;
  localparam int DLY_MAX_NS   = 700;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_CYC     = DLY_STEP_NS / CLK_PERIOD_NS;
  localparam int DLY_CNT_W    = 8;
  localparam logic [DLY_CNT_W-1:0] DLY_MAX_CYC = DLY_CNT_W'(DLY_MAX_NS / CLK_PERIOD_NS);
  localparam logic [DLY_CNT_W-1:0] STEP_CYC_L  = DLY_CNT_W'(STEP_CYC);
  localparam logic [DLY_CNT_W-1:0] DLY_ZERO    = 8'h00;
  typedef enum logic [1:0] {AHP_IDLE, AHP_READY, AHP_WAIT_REL, AHP_GAP} ahp_state_t;

  // converts a delay code into a cycle count, never beyond 700 ns
  function automatic logic [DLY_CNT_W-1:0] ahp_dly_cycles(input logic [DLY_CODE_W-1:0] code);
    logic [DLY_CNT_W-1:0] c;
    c = DLY_CNT_W'(code) * STEP_CYC_L;
    if (c > DLY_MAX_CYC) c = DLY_MAX_CYC;
    return c;
  endfunction
endpackage

//--- ahp_sva.sv
`timescale 1ns/1ps
module ahp_sva
  import ahp_pkg::*;
(
  // clock, reset, configuration
  input wire logic                  SYS_CLK,
  input wire logic                  RST,
  input wire logic [1:0]            PROTO,
  input wire logic                  DIR_OUT,
  input wire logic                  POL_HIGH,
  input wire logic [DLY_CODE_W-1:0] DELAY_CODE,
  // link
  input wire logic                  ready_line,
  input wire logic                  legacy_input_strobe,
  input wire logic [DATA_W-1:0]     dev_data,
  input wire logic                  dev_data_oe,
  input wire logic                  per_data_oe
);
  logic       act;
  logic       rdy_on;
  logic       stb_on;
  logic [4:0] stb_hist;
  logic [7:0] gap_cnt;
  assign act    = (PROTO == PROTO_LEGACY) ? 1'b0 : POL_HIGH;
  assign rdy_on = ready_line == act;
  assign stb_on = legacy_input_strobe == act;
  ////////////////////////////////////////////////////////////////
  // history covers the two-flop sync plus the edge detect
  always_ff @(posedge SYS_CLK) begin
    stb_hist <= RST ? 5'h00 : {stb_hist[3:0], stb_on};
  end
  // saturates at reset so the first ready is never judged a short gap
  always_ff @(posedge SYS_CLK) begin
    if (RST) gap_cnt <= 8'hff;
    else if (stb_on) gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_reset_lines_idle: assert property ($fell(RST) |-> !rdy_on && !stb_on)
    else $error("ready or strobe active after reset");
  a_strobe_drops_ready: assert property
    (PROTO == PROTO_LEGACY && rdy_on && stb_on |-> ##[1:4] !rdy_on)
    else $error("ready not dropped after strobe");
  a_ready_holds_level: assert property (rdy_on && !stb_on && stb_hist == 5'h00 |=> rdy_on)
    else $error("ready dropped with no strobe");
  a_ready_after_gap: assert property
    ($rose(rdy_on) && !stb_on |-> gap_cnt >= STEP_CYC * DELAY_CODE)
    else $error("ready returned before the gap");
  a_no_early_ready: assert property ($rose(rdy_on) && DIR_OUT |-> !$past(stb_on))
    else $error("ready raised while strobe active");
  a_out_drives_data: assert property (DIR_OUT && rdy_on |-> dev_data_oe)
    else $error("output data not driven");
  a_out_data_steady: assert property (DIR_OUT && rdy_on |=> !rdy_on || $stable(dev_data))
    else $error("output data moved while ready");
  a_one_way_bus: assert property (!(dev_data_oe && per_data_oe) && (DIR_OUT || !dev_data_oe))
    else $error("both ends drive the data bus");
  c_legacy_out: cover property (PROTO == PROTO_LEGACY && DIR_OUT && $fell(rdy_on));
  c_legacy_in: cover property (PROTO == PROTO_LEGACY && !DIR_OUT && $fell(rdy_on));
  c_level_gap: cover property (PROTO == PROTO_LEVEL && $rose(rdy_on) && DELAY_CODE == 3'h7);
endmodule

//--- async_handshake_port_bench.sv
`timescale 1ns/1ps
module async_handshake_port_bench;
  import ahp_pkg::*;
  logic                  sys_clk = 1'b0, rst = 1'b1, dir_out = 1'b0, pol_high = 1'b0;
  logic                  edge_latch = 1'b0, in_ready = 1'b0, out_valid = 1'b0, tx_valid = 1'b0;
  logic [1:0]            proto = PROTO_LEGACY;
  logic [DLY_CODE_W-1:0] delay_code = 3'h0;
  logic [DATA_W-1:0]     out_data = 32'h0, tx_data = 32'h0, in_data, rx_data;
  logic                  in_valid, out_ready, busy, tx_ready, rx_valid;
  logic [DATA_W-1:0]     exp_q[$];
  int                    fail_count = 0, checks = 0, seed = 32'hbf42d4df;
  ahp_link_if ahp_link_if_i ();
  ahp_device ahp_device_i (.SYS_CLK(sys_clk), .RST(rst), .LINK(ahp_link_if_i), .PROTO(proto),
    .DIR_OUT(dir_out), .POL_HIGH(pol_high), .EDGE_LATCH(edge_latch), .DELAY_CODE(delay_code),
    .IN_VALID(in_valid), .IN_DATA(in_data), .IN_READY(in_ready), .OUT_VALID(out_valid),
    .OUT_DATA(out_data), .OUT_READY(out_ready), .BUSY(busy));
  ahp_peripheral ahp_peripheral_i (.SYS_CLK(sys_clk), .RST(rst), .LINK(ahp_link_if_i),
    .PROTO(proto), .DIR_OUT(dir_out), .POL_HIGH(pol_high), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data));
  ahp_sva ahp_sva_i (.SYS_CLK(sys_clk), .RST(rst), .PROTO(proto), .DIR_OUT(dir_out),
    .POL_HIGH(pol_high), .DELAY_CODE(delay_code), .ready_line(ahp_link_if_i.ready_line),
    .legacy_input_strobe(ahp_link_if_i.legacy_input_strobe), .dev_data(ahp_link_if_i.dev_data),
    .dev_data_oe(ahp_link_if_i.dev_data_oe), .per_data_oe(ahp_link_if_i.per_data_oe));
  ////////////////////////////////////////////////////////////////
  task automatic check_eq(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // idle pin level: legacy lines are active low whatever the polarity bit says
  function automatic logic idle_lvl(input logic [1:0] p, input logic pol);
    return (p == PROTO_LEGACY) ? 1'b1 : !pol;
  endfunction
  // valid held until the edge at which ready is high, then dropped
  task automatic send(input logic [DATA_W-1:0] w);
    int n;
    n = 0;
    exp_q.push_back(w);
    @(posedge sys_clk);
    out_valid <= dir_out;
    tx_valid <= !dir_out;
    out_data <= w;
    tx_data <= w;
    do @(negedge sys_clk); while ((dir_out ? out_ready : tx_ready) !== 1'b1 && ++n < 4000);
    @(posedge sys_clk);
    out_valid <= 1'b0;
    tx_valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // random pops stall the device input side
  always @(posedge sys_clk) begin
    in_ready <= 1'($random(seed));
  end
  always @(negedge sys_clk) begin
    if (!rst && (dir_out ? rx_valid === 1'b1 : (in_valid === 1'b1 && in_ready))) begin
      check_eq(dir_out ? rx_data : in_data, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      rst <= 1'b1;
      proto <= c[2] ? PROTO_LEVEL : PROTO_LEGACY;
      dir_out <= c[0];
      pol_high <= c[1];
      edge_latch <= 1'($random(seed));
      delay_code <= (c[1:0] == 2'h3) ? 3'h7 : (c == 0) ? 3'h0 : 3'($random(seed));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check_eq(ahp_link_if_i.ready_line, idle_lvl(proto, pol_high));
      check_eq(ahp_link_if_i.legacy_input_strobe, idle_lvl(proto, pol_high));
      check_eq(busy, 1'b0);
      send(32'h00000000);
      send(32'hffffffff);
      repeat (4) send($random(seed));
      for (int n = 0; n < 4000 && exp_q.size() != 0; n++) @(posedge sys_clk);
      check_eq(exp_q.size(), 0);
    end
    tally_and_finish();
  end
endmodule
